/* fbdc_di_enc.sv */
// Purpose: Value byte of one discrete-input image
// Assumes: Function inputs come from logic on this clock
// Notes:   One cycle of latency
`timescale 1ns/1ns
module fbdc_di_enc (
  input  wire logic                  clk_i,        // Clock
  input  wire logic                  rst_n_i,      // Sync reset, low
  input  wire logic [1:0]            sel_i,        // Bound function
  input  wire logic                  empty_pipe_i, // Empty pipe active
  input  wire logic                  low_flow_i,   // Low flow cutoff active
  input  wire fbdc_pkg::fbdc_verif_t verif_i,      // Verification state
  output logic [7:0]                 val_o         // Value byte
);

  typedef struct packed {
    logic [7:0] val;
  } fbdc_enc_st_t;

  fbdc_enc_st_t q;
  fbdc_enc_st_t d;

  always_comb
  begin
    d.val = 8'h00;
    case (sel_i)
      fbdc_pkg::DI_SEL_EPD: d.val = {7'h00, empty_pipe_i};
      fbdc_pkg::DI_SEL_LFC: d.val = {7'h00, low_flow_i};
      fbdc_pkg::DI_SEL_VER:
      begin
        d.val[verif_i.state] = 1'b1;
        case (verif_i.result)
          fbdc_pkg::VRS_FAIL: d.val[fbdc_pkg::VER_FAIL_BIT] = 1'b1;
          fbdc_pkg::VRS_PASS: d.val[fbdc_pkg::VER_PASS_BIT] = 1'b1;
          default:            d.val[fbdc_pkg::VER_NDONE_BIT] = 1'b1;
        endcase
      end
      default: d.val = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign val_o = q.val;

endmodule

/* fbdc_img_hold.sv */
// Purpose: Assemble and retain one output module image
// Assumes: Bytes arrive in order, byte 1 first
// Notes:   Image changes only on the last byte
`timescale 1ns/1ns
module fbdc_img_hold #(
  parameter int unsigned NB = 5
) (
  input  wire logic            clk_i,   // Clock
  input  wire logic            rst_n_i, // Sync reset, low
  input  wire logic            load_i,  // Byte for this block
  input  wire logic            last_i,  // Final byte of image
  input  wire logic [7:0]      data_i,  // Byte value
  output logic [8*NB-1:0]      img_o    // Byte 1 at the top
);

  typedef struct packed {
    logic [8*NB-1:0] shd;
    logic [8*NB-1:0] img;
  } fbdc_hold_st_t;

  fbdc_hold_st_t q;
  fbdc_hold_st_t d;

  always_comb
  begin
    d = q;
    if (load_i)
    begin
      d.shd = {q.shd[8*NB-9:0], data_i};
      if (last_i)
      begin
        d.img = {q.shd[8*NB-9:0], data_i};
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign img_o = q.img;

endmodule

/* fbdc_master_model.sv */
// Purpose: Cyclic master stand-in: output images and input image requests
// Assumes: Same clock as the framer
// Notes:   Released image data and request address and slot lines show the inverse of their last value
`timescale 1ns/1ns
module fbdc_master_model (
  input  wire logic               clk_i,      // Clock
  output fbdc_pkg::fbdc_rx_t      rx_o,       // Output image bytes
  output logic                    req_o,      // Image request
  output logic [6:0]              req_addr_o, // Requested station
  output logic [3:0]              req_slot_o, // Requested slot
  input  wire fbdc_pkg::fbdc_tx_t tx_i        // Input image bytes
);
  initial
  begin
    rx_o       = '0;
    req_o      = 1'b0;
    req_addr_o = 7'h00;
    req_slot_o = 4'h0;
  end

  task automatic beat(input logic sof, input logic [6:0] a, input logic [3:0] s, input logic [7:0] d);
    @(posedge clk_i);
    rx_o <= '{1'b1, sof, a, s, d};
  endtask

  task automatic release_rx();
    @(posedge clk_i);
    rx_o.valid <= 1'b0;
    rx_o.data  <= ~rx_o.data;
  endtask

  task automatic send_float_img(input logic [6:0] a, input logic [3:0] s, input logic [39:0] img);
    for (int i = 0; i < 5; i++)
      beat(i == 0, a, s, img[39-8*i -: 8]);
    release_rx();
  endtask

  task automatic send_ctrl_img(input logic [6:0] a, input logic [3:0] s, input logic [15:0] img);
    beat(1'b1, a, s, img[15:8]);
    beat(1'b0, a, s, img[7:0]);
    release_rx();
  endtask

  task automatic request(input logic [6:0] a, input logic [3:0] s,
                         output fbdc_pkg::fbdc_tx_t b1, output fbdc_pkg::fbdc_tx_t b2);
    @(posedge clk_i);
    req_o      <= 1'b1;
    req_addr_o <= a;
    req_slot_o <= s;
    @(posedge clk_i);
    req_o      <= 1'b0;
    req_addr_o <= ~a;
    req_slot_o <= ~s;
    #1;
    b1 = tx_i;
    @(posedge clk_i);
    #1;
    b2 = tx_i;
  endtask
endmodule

/* fbdc_pkg.sv */
// Purpose: Shared constants and carriers for the cyclic module framer
// Assumes: One 125 MHz clock, synchronous active-low reset
// Notes:   Module images travel byte by byte, byte 1 first
package fbdc_pkg;

  // Fixed slot numbers
  localparam logic [3:0] SLOT_AO0 = 4'h8;
  localparam logic [3:0] SLOT_AO1 = 4'h9;
  localparam logic [3:0] SLOT_DI0 = 4'ha;
  localparam logic [3:0] SLOT_DI1 = 4'hb;
  localparam logic [3:0] SLOT_DO0 = 4'hc;
  localparam logic [3:0] SLOT_DO1 = 4'hd;
  localparam logic [3:0] SLOT_DO2 = 4'he;

  // Image lengths in bytes
  localparam int unsigned NB_AO  = 5;
  localparam int unsigned NB_DO  = 2;
  localparam logic [2:0]  LEN_AO = 3'h5;
  localparam logic [2:0]  LEN_DO = 3'h2;

  // Station address
  localparam logic [6:0] ADDR_RST = 7'h7e;
  localparam logic [6:0] ADDR_MAX = 7'h7e;

  // Discrete-input function select
  localparam logic [1:0] DI_SEL_EPD = 2'h0;
  localparam logic [1:0] DI_SEL_LFC = 2'h1;
  localparam logic [1:0] DI_SEL_VER = 2'h2;
  localparam logic [3:0] DI_SEL_RST = 4'h4;
  localparam logic [7:0] DI_STAT_RST = 8'h80;

  // Discrete-output control values
  localparam logic [7:0] DO_VAL_OFF = 8'h00;
  localparam logic [7:0] DO_VAL_ON  = 8'h01;

  // Verification state codes and one-hot positions
  localparam logic [1:0] VST_NDONE = 2'h0;
  localparam logic [1:0] VST_FAIL  = 2'h1;
  localparam logic [1:0] VST_BUSY  = 2'h2;
  localparam logic [1:0] VST_READY = 2'h3;
  localparam logic [1:0] VRS_FAIL  = 2'h0;
  localparam logic [1:0] VRS_PASS  = 2'h1;
  localparam logic [1:0] VRS_NDONE = 2'h2;
  localparam int unsigned VER_FAIL_BIT  = 4;
  localparam int unsigned VER_PASS_BIT  = 5;
  localparam int unsigned VER_NDONE_BIT = 6;

  // Register byte offsets
  localparam logic [7:0] REG_ADDR   = 8'h00;
  localparam logic [7:0] REG_DI_SEL = 8'h04;
  localparam logic [7:0] REG_DI_ST  = 8'h08;
  localparam logic [7:0] REG_IRQ_ST = 8'h0c;
  localparam logic [7:0] REG_IRQ_EN = 8'h10;
  localparam logic [7:0] REG_DO     = 8'h14;
  localparam logic [7:0] REG_AO0    = 8'h18;
  localparam logic [7:0] REG_AO1    = 8'h1c;
  localparam logic [7:0] REG_AO_ST  = 8'h20;
  localparam logic [7:0] REG_LIVE   = 8'h24;

  // Interrupt bit positions
  localparam int unsigned IRQ_W    = 7;
  localparam int unsigned IRQ_AO0  = 0;
  localparam int unsigned IRQ_DO0  = 2;
  localparam int unsigned IRQ_RXER = 5;
  localparam int unsigned IRQ_TXDN = 6;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_STAT = 2'b10
  } fbdc_tx_state_t;

  typedef struct packed {
    logic       valid;
    logic       sof;
    logic [6:0] addr;
    logic [3:0] slot;
    logic [7:0] data;
  } fbdc_rx_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } fbdc_tx_t;

  typedef struct packed {
    logic [31:0] value;
    logic [7:0]  status;
  } fbdc_ao_t;

  typedef struct packed {
    logic [1:0] state;
    logic [1:0] result;
  } fbdc_verif_t;

endpackage

/* fbdc_top.sv */
// Purpose: Cyclic image framer for analog-output, discrete-in and discrete-out slots
// Assumes: Bus engine on the same clock delivers and requests module images
// Notes:   Registers over a plain strobe port, read data one cycle later
`timescale 1ns/1ns
module fbdc_top (
  input  wire logic                  clk_i,           // 125 MHz clock
  input  wire logic                  rst_n_i,         // Sync reset, low
  input  wire logic [7:0]            reg_addr_i,      // Register byte address
  input  wire logic [31:0]           reg_wdata_i,     // Write data
  input  wire logic                  reg_wr_i,        // Write strobe
  input  wire logic                  reg_rd_i,        // Read strobe
  output logic [31:0]                reg_rdata_o,     // Read data, next cycle
  input  wire fbdc_pkg::fbdc_rx_t    rx_i,            // Output image bytes
  input  wire logic                  tx_req_i,        // Input image request
  input  wire logic [6:0]            tx_addr_i,       // Requested station
  input  wire logic [3:0]            tx_slot_i,       // Requested slot
  output fbdc_pkg::fbdc_tx_t         tx_o,            // Input image bytes
  input  wire logic                  empty_pipe_i,    // Empty pipe active
  input  wire logic                  low_flow_i,      // Low flow cutoff active
  input  wire fbdc_pkg::fbdc_verif_t verif_i,         // Verification state
  output fbdc_pkg::fbdc_ao_t         ao0_o,           // External temperature
  output fbdc_pkg::fbdc_ao_t         ao1_o,           // External density
  output logic                       flow_override_o, // Flow override enabled
  output logic                       start_verif_o,   // Verification start enabled
  output logic                       switch_on_o,     // Switch output conductive
  output logic [6:0]                 station_addr_o,  // Current station address
  output logic                       irq_o            // Interrupt, level
);

  typedef struct packed {
    logic                     rx_on;
    logic [3:0]               rx_slot;
    logic [2:0]               rx_idx;
    logic [6:0]               addr;
    logic [3:0]               di_sel;
    logic [15:0]              di_stat;
    logic [6:0]               ip;
    logic [6:0]               ie;
    logic [31:0]              rdata;
    fbdc_pkg::fbdc_tx_state_t tx_st;
    logic                     tx_di;
    fbdc_pkg::fbdc_tx_t       tx;
    logic [2:0]               do_en;
    logic                     irq;
  } fbdc_top_st_t;

  fbdc_top_st_t q;
  fbdc_top_st_t d;

  logic       sof_ok;
  logic [3:0] cur_slot;
  logic [2:0] cur_idx;
  logic       cur_ao;
  logic       cur_do;
  logic       ld;
  logic [2:0] cur_len;
  logic       last;
  logic       rx_err;
  logic [1:0] ao_ld;
  logic [2:0] do_ld;
  logic       tx_go;
  logic       tx_done;
  logic [6:0] ev;
  logic [6:0] ip_clr;
  logic [39:0] ao_img [2];
  logic [15:0] do_img [3];
  logic [7:0]  di_val [2];

  assign sof_ok   = rx_i.valid & rx_i.sof & (rx_i.addr == q.addr);
  assign cur_slot = rx_i.sof ? rx_i.slot : q.rx_slot;
  assign cur_idx  = rx_i.sof ? 3'h0 : q.rx_idx + 3'h1;
  assign cur_ao   = (cur_slot == fbdc_pkg::SLOT_AO0) | (cur_slot == fbdc_pkg::SLOT_AO1);
  assign cur_do   = (cur_slot == fbdc_pkg::SLOT_DO0) | (cur_slot == fbdc_pkg::SLOT_DO1) |
                    (cur_slot == fbdc_pkg::SLOT_DO2);

  // only output slots take master bytes
  assign ld      = rx_i.valid & (rx_i.sof ? sof_ok : q.rx_on) & (cur_ao | cur_do);
  assign cur_len = cur_ao ? fbdc_pkg::LEN_AO : fbdc_pkg::LEN_DO;
  assign last    = (cur_idx == cur_len - 3'h1);

  assign rx_err = (rx_i.valid & rx_i.sof & q.rx_on) |
                  (sof_ok & ((rx_i.slot == fbdc_pkg::SLOT_DI0) | (rx_i.slot == fbdc_pkg::SLOT_DI1)));

  assign ao_ld[0] = ld & (cur_slot == fbdc_pkg::SLOT_AO0);
  assign ao_ld[1] = ld & (cur_slot == fbdc_pkg::SLOT_AO1);
  assign do_ld[0] = ld & (cur_slot == fbdc_pkg::SLOT_DO0);
  assign do_ld[1] = ld & (cur_slot == fbdc_pkg::SLOT_DO1);
  assign do_ld[2] = ld & (cur_slot == fbdc_pkg::SLOT_DO2);

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ao
      fbdc_img_hold #(
        .NB (fbdc_pkg::NB_AO)
      ) u_hold (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .load_i  (ao_ld[g]),
        .last_i  (last),
        .data_i  (rx_i.data),
        .img_o   (ao_img[g])
      );
    end
    for (g = 0; g < 3; g++)
    begin : g_do
      fbdc_img_hold #(
        .NB (fbdc_pkg::NB_DO)
      ) u_hold (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .load_i  (do_ld[g]),
        .last_i  (last),
        .data_i  (rx_i.data),
        .img_o   (do_img[g])
      );
    end
    for (g = 0; g < 2; g++)
    begin : g_di
      fbdc_di_enc u_enc (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .sel_i        (q.di_sel[2*g +: 2]),
        .empty_pipe_i (empty_pipe_i),
        .low_flow_i   (low_flow_i),
        .verif_i      (verif_i),
        .val_o        (di_val[g])
      );
    end
  endgenerate

  assign tx_go = tx_req_i & (q.tx_st == fbdc_pkg::TX_IDLE) & (tx_addr_i == q.addr) &
                 ((tx_slot_i == fbdc_pkg::SLOT_DI0) | (tx_slot_i == fbdc_pkg::SLOT_DI1));
  assign tx_done = (q.tx_st == fbdc_pkg::TX_STAT);

  assign ev = {tx_done, rx_err, do_ld & {3{last}}, ao_ld & {2{last}}};
  assign ip_clr = (reg_wr_i && reg_addr_i == fbdc_pkg::REG_IRQ_ST) ? reg_wdata_i[6:0] : 7'h00;

  always_comb
  begin
    d = q;
    d.tx = '0;
    d.rdata = 32'h0000_0000;

    // Output image tracking
    if (rx_i.valid)
    begin
      d.rx_on = ld & ~last;
      if (ld)
      begin
        d.rx_slot = cur_slot;
        d.rx_idx  = cur_idx;
      end
    end

    for (int k = 0; k < 3; k++)
    begin
      if (do_img[k][15:8] == fbdc_pkg::DO_VAL_ON)
      begin
        d.do_en[k] = 1'b1;
      end
      else if (do_img[k][15:8] == fbdc_pkg::DO_VAL_OFF)
      begin
        d.do_en[k] = 1'b0;
      end
    end

    case (q.tx_st)
      fbdc_pkg::TX_IDLE:
      begin
        if (tx_go)
        begin
          d.tx_di    = (tx_slot_i == fbdc_pkg::SLOT_DI1);
          d.tx.valid = 1'b1;
          d.tx.data  = (tx_slot_i == fbdc_pkg::SLOT_DI1) ? di_val[1] : di_val[0];
          d.tx_st    = fbdc_pkg::TX_STAT;
        end
      end
      fbdc_pkg::TX_STAT:
      begin
        d.tx.valid = 1'b1;
        d.tx.last  = 1'b1;
        d.tx.data  = q.tx_di ? q.di_stat[15:8] : q.di_stat[7:0];
        d.tx_st    = fbdc_pkg::TX_IDLE;
      end
      default:
      begin
        d.tx_st = fbdc_pkg::TX_IDLE;
      end
    endcase

    // Register writes
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        fbdc_pkg::REG_ADDR:
        begin
          if (reg_wdata_i[6:0] <= fbdc_pkg::ADDR_MAX)
          begin
            d.addr = reg_wdata_i[6:0];
          end
        end
        fbdc_pkg::REG_DI_SEL: d.di_sel  = reg_wdata_i[3:0];
        fbdc_pkg::REG_DI_ST:  d.di_stat = reg_wdata_i[15:0];
        fbdc_pkg::REG_IRQ_EN: d.ie      = reg_wdata_i[6:0];
        default:              d.ie      = q.ie;
      endcase
    end

    // Sticky events, set beats clear
    d.ip  = (q.ip & ~ip_clr) | ev;
    d.irq = |(d.ip & d.ie);

    // Register reads
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        fbdc_pkg::REG_ADDR:   d.rdata = {25'h0, q.addr};
        fbdc_pkg::REG_DI_SEL: d.rdata = {28'h0, q.di_sel};
        fbdc_pkg::REG_DI_ST:  d.rdata = {16'h0, q.di_stat};
        fbdc_pkg::REG_IRQ_ST: d.rdata = {25'h0, q.ip};
        fbdc_pkg::REG_IRQ_EN: d.rdata = {25'h0, q.ie};
        fbdc_pkg::REG_DO:
        begin
          d.rdata = {do_img[2][7:0], do_img[1][7:0], do_img[0][7:0], 5'h0, q.do_en};
        end
        fbdc_pkg::REG_AO0:    d.rdata = ao_img[0][39:8];
        fbdc_pkg::REG_AO1:    d.rdata = ao_img[1][39:8];
        fbdc_pkg::REG_AO_ST:  d.rdata = {16'h0, ao_img[1][7:0], ao_img[0][7:0]};
        fbdc_pkg::REG_LIVE:
        begin
          d.rdata = {8'h0, di_val[1], di_val[0], 6'h0, tx_done, q.rx_on};
        end
        default:              d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      q         <= '0;
      q.addr    <= fbdc_pkg::ADDR_RST;
      q.di_sel  <= fbdc_pkg::DI_SEL_RST;
      q.di_stat <= {fbdc_pkg::DI_STAT_RST, fbdc_pkg::DI_STAT_RST};
      q.tx_st   <= fbdc_pkg::TX_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata_o     = q.rdata;
  assign tx_o            = q.tx;
  assign ao0_o           = ao_img[0];
  assign ao1_o           = ao_img[1];
  assign flow_override_o = q.do_en[0];
  assign start_verif_o   = q.do_en[1];
  assign switch_on_o     = q.do_en[2];
  assign station_addr_o  = q.addr;
  assign irq_o           = q.irq;

endmodule

/* fbdc_top_chk.sv */
// Purpose: Port-level checks of the cyclic image framer
// Assumes: Single clock, synchronous active-low reset
// Notes:   Image checks expect back-to-back beats
`timescale 1ns/1ns
module fbdc_top_chk (
  input wire logic               clk_i,           // Clock
  input wire logic               rst_n_i,         // Sync reset, low
  input wire logic [7:0]         reg_addr_i,      // Register address
  input wire logic               reg_wr_i,        // Write strobe
  input wire logic               reg_rd_i,        // Read strobe
  input wire logic [31:0]        reg_rdata_o,     // Read data
  input wire fbdc_pkg::fbdc_rx_t rx_i,            // Output image bytes
  input wire logic               tx_req_i,        // Image request
  input wire logic [6:0]         tx_addr_i,       // Requested station
  input wire logic [3:0]         tx_slot_i,       // Requested slot
  input wire fbdc_pkg::fbdc_tx_t tx_o,            // Input image bytes
  input wire fbdc_pkg::fbdc_ao_t ao0_o,           // First float image
  input wire fbdc_pkg::fbdc_ao_t ao1_o,           // Second float image
  input wire logic               flow_override_o, // Flow override
  input wire logic               start_verif_o,   // Start verification
  input wire logic               switch_on_o,     // Switch conductive
  input wire logic [6:0]         station_addr_o   // Station address
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic tx_take;
  assign tx_take = tx_req_i && tx_addr_i == station_addr_o && !(tx_o.valid && !tx_o.last)
                   && (tx_slot_i == fbdc_pkg::SLOT_DI0 || tx_slot_i == fbdc_pkg::SLOT_DI1);

  sequence s_tx_pair;
    (tx_o.valid && !tx_o.last) ##1 (tx_o.valid && tx_o.last);
  endsequence
  sequence s_float_img;
    rx_i.valid && rx_i.sof && rx_i.addr == station_addr_o && rx_i.slot == fbdc_pkg::SLOT_AO0
    ##1 (rx_i.valid && !rx_i.sof) [*4];
  endsequence
  sequence s_ctrl_img(s, v);
    rx_i.valid && rx_i.sof && rx_i.addr == station_addr_o && rx_i.slot == s && rx_i.data == v
    ##1 rx_i.valid && !rx_i.sof;
  endsequence
  property p_ctrl(s, v, lvl, e);
    s_ctrl_img(s, v) |-> ##2 lvl == e;
  endproperty

  AST_RST_ADDR: assert property (disable iff (1'b0) !rst_n_i |=> station_addr_o == 7'h7e && !tx_o.valid)
    else $error("station address not 126 after reset");
  AST_TX_PAIR: assert property (tx_take |=> s_tx_pair)
    else $error("input image not value then status");
  AST_TX_NONE: assert property (!tx_take && !tx_o.valid |=> !tx_o.valid)
    else $error("input image sent without accepted request");
  AST_FLOAT: assert property (s_float_img |=> ao0_o == {$past(rx_i.data, 5), $past(rx_i.data, 4),
    $past(rx_i.data, 3), $past(rx_i.data, 2), $past(rx_i.data, 1)})
    else $error("float image bytes misplaced");
  AST_HOLD: assert property ($changed(ao0_o) || $changed(ao1_o) |-> $past(rx_i.valid))
    else $error("float image changed without a received byte");
  AST_ADDR: assert property ($changed(station_addr_o) |-> $past(reg_wr_i) && $past(reg_addr_i) == 8'h00)
    else $error("station address changed without a write");
  AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
  AST_FLOW_ON: assert property (p_ctrl(fbdc_pkg::SLOT_DO0, 8'h01, flow_override_o, 1'b1))
    else $error("flow override not enabled");
  AST_VERIF_OFF: assert property (p_ctrl(fbdc_pkg::SLOT_DO1, 8'h00, start_verif_o, 1'b0))
    else $error("start verification not disabled");
  AST_SWITCH_ON: assert property (p_ctrl(fbdc_pkg::SLOT_DO2, 8'h01, switch_on_o, 1'b1))
    else $error("switch output not conductive");
endmodule

bind fbdc_top fbdc_top_chk chk_u (
  .clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rx_i, .tx_req_i, .tx_addr_i,
  .tx_slot_i, .tx_o, .ao0_o, .ao1_o, .flow_override_o, .start_verif_o, .switch_on_o, .station_addr_o
);

/* fbdc_top_tb.sv */
// Purpose: Self-checking bench of the cyclic image framer
// Assumes: Master stand-in drives the image side
// Notes:   One task per scenario
`timescale 1ns/1ns
module fbdc_top_tb;
  logic                  clk_i       = 1'b0;
  logic                  rst_n_i     = 1'b0;
  logic [7:0]            reg_addr_i  = 8'h00;
  logic [31:0]           reg_wdata_i = 32'h0;
  logic                  reg_wr_i    = 1'b0;
  logic                  reg_rd_i    = 1'b0;
  logic                  empty_pipe  = 1'b0;
  logic                  low_flow    = 1'b0;
  fbdc_pkg::fbdc_verif_t verif       = '0;
  logic [31:0]           rdata;
  fbdc_pkg::fbdc_rx_t    rx;
  logic                  req;
  logic [6:0]            req_addr;
  logic [3:0]            req_slot;
  fbdc_pkg::fbdc_tx_t    tx;
  fbdc_pkg::fbdc_ao_t    ao0;
  fbdc_pkg::fbdc_ao_t    ao1;
  logic [2:0]            ctrl;
  logic [6:0]            station;
  logic                  irq;
  int                    mismatches  = 0;
  int                    num_checks  = 0;
  int                    cycles      = 0;

  always #4 clk_i = ~clk_i;

  fbdc_top dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .rx_i(rx), .tx_req_i(req),
    .tx_addr_i(req_addr), .tx_slot_i(req_slot), .tx_o(tx), .empty_pipe_i(empty_pipe),
    .low_flow_i(low_flow), .verif_i(verif), .ao0_o(ao0), .ao1_o(ao1), .flow_override_o(ctrl[2]),
    .start_verif_o(ctrl[1]), .switch_on_o(ctrl[0]), .station_addr_o(station), .irq_o(irq)
  );

  fbdc_master_model mst_u (
    .clk_i(clk_i), .rx_o(rx), .req_o(req), .req_addr_o(req_addr), .req_slot_o(req_slot), .tx_i(tx)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic t_reset();
    logic [31:0] d;
    check(station, 7'h7e);
    check({ctrl, irq, ao0}, 44'h0);
    rd(fbdc_pkg::REG_ADDR, d);
    check(d, 32'h7e);
    rd(fbdc_pkg::REG_DI_SEL, d);
    check(d, 32'h4);
    rd(fbdc_pkg::REG_DI_ST, d);
    check(d, 32'h8080);
  endtask

  task automatic t_float();
    logic [31:0] d;
    mst_u.send_float_img(7'h7e, fbdc_pkg::SLOT_AO0, 40'h41200000c0);
    mst_u.send_float_img(7'h7e, fbdc_pkg::SLOT_AO1, 40'hc2c8000040);
    wait_cyc(2);
    check(ao0, 40'h41200000c0);
    check({ao1, irq}, {40'hc2c8000040, 1'b0});
    rd(fbdc_pkg::REG_AO0, d);
    check(d, 32'h41200000);
    rd(fbdc_pkg::REG_AO_ST, d);
    check(d, 32'h40c0);
    mst_u.send_float_img(7'h05, fbdc_pkg::SLOT_AO0, 40'h0);
    mst_u.send_float_img(7'h7e, fbdc_pkg::SLOT_DI0, 40'h0);
    wait_cyc(2);
    check(ao0, 40'h41200000c0);
    rd(fbdc_pkg::REG_IRQ_ST, d);
    check(d, 32'h23);
    wr(fbdc_pkg::REG_IRQ_EN, 32'h1);
    wait_cyc(2);
    check(irq, 1'b1);
    wr(fbdc_pkg::REG_IRQ_ST, 32'h7f);
    wait_cyc(2);
    check(irq, 1'b0);
    wr(fbdc_pkg::REG_IRQ_EN, 32'h0);
  endtask

  task automatic t_ctrl();
    logic [2:0] exp;
    logic [31:0] d;
    exp = 3'b000;
    for (int i = 0; i < 3; i++)
    begin
      mst_u.send_ctrl_img(7'h7e, 4'(12 + i), 16'h0180);
      wait_cyc(3);
      exp[2-i] = 1'b1;
      check(ctrl, exp);
    end
    mst_u.send_ctrl_img(7'h7e, fbdc_pkg::SLOT_DO1, 16'h0280);
    wait_cyc(3);
    check(ctrl, 3'b111);
    rd(fbdc_pkg::REG_DO, d);
    check(d, 32'h80808007);
    rd(fbdc_pkg::REG_IRQ_ST, d);
    check(d, 32'h1c);
    for (int i = 0; i < 3; i++)
    begin
      mst_u.send_ctrl_img(7'h7e, 4'(12 + i), 16'h0080);
      wait_cyc(3);
      exp[2-i] = 1'b0;
      check(ctrl, exp);
    end
  endtask

  task automatic t_state();
    fbdc_pkg::fbdc_tx_t b1;
    fbdc_pkg::fbdc_tx_t b2;
    @(posedge clk_i);
    empty_pipe <= 1'b1;
    wait_cyc(2);
    mst_u.request(7'h7e, fbdc_pkg::SLOT_DI0, b1, b2);
    check({b1, b2}, {2'b10, 8'h01, 2'b11, 8'h80});
    mst_u.request(7'h7e, fbdc_pkg::SLOT_DI1, b1, b2);
    check({b1, b2}, {2'b10, 8'h00, 2'b11, 8'h80});
    mst_u.request(7'h7e, fbdc_pkg::SLOT_DO0, b1, b2);
    check({b1, b2}, 20'h0);
    wr(fbdc_pkg::REG_DI_SEL, 32'h2);
    for (int s = 0; s < 4; s++)
      for (int r = 0; r < 4; r++)
      begin
        @(posedge clk_i);
        verif <= '{2'(s), 2'(r)};
        wait_cyc(2);
        mst_u.request(7'h7e, fbdc_pkg::SLOT_DI0, b1, b2);
        check(b1.data, (8'h01 << s) | (8'h10 << (r == 3 ? 2 : r)));
      end
    @(posedge clk_i);
    low_flow <= 1'b1;
    wr(fbdc_pkg::REG_DI_SEL, 32'hd);
    wait_cyc(2);
    mst_u.request(7'h7e, fbdc_pkg::SLOT_DI0, b1, b2);
    check(b1.data, 8'h01);
    mst_u.request(7'h7e, fbdc_pkg::SLOT_DI1, b1, b2);
    check(b1.data, 8'h00);
    wr(fbdc_pkg::REG_DI_SEL, 32'h4);
  endtask

  task automatic t_station();
    logic [31:0]        d;
    fbdc_pkg::fbdc_tx_t b1;
    fbdc_pkg::fbdc_tx_t b2;
    wr(fbdc_pkg::REG_ADDR, 32'h7f);
    rd(fbdc_pkg::REG_ADDR, d);
    check(d, 32'h7e);
    wr(fbdc_pkg::REG_ADDR, 32'h05);
    wait_cyc(1);
    check(station, 7'h05);
    mst_u.request(7'h7e, fbdc_pkg::SLOT_DI0, b1, b2);
    check(b1, 10'h0);
    mst_u.request(7'h05, fbdc_pkg::SLOT_DI0, b1, b2);
    check(b1.valid, 1'b1);
    wr(fbdc_pkg::REG_ADDR, 32'h7e);
    rd(8'h3c, d);
    check(d, 32'h0);
  endtask

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wait_cyc(1);
    t_reset();
    t_float();
    t_ctrl();
    t_state();
    t_station();
    finish_test();
  end
endmodule
